// file: rtl/video_delay_ctrl.sv
// video delay controller: mode outputs, field memory strobes, field delay and serial control
//
// Function
// - film select output low asks camera mode, high asks film mode.
// - picture-in-picture bypass forces film select high and interpolation low.
// - interpolation output high turns companion vertical interpolation on, low off.
// - vertical reference pins swap direction in picture-in-picture mode.
// - a horizontal reference pulse goes to the downstream part.
// - separate read and write strobes for memories a and d, one shared pointer reset.
// - memory d chroma carries two bits of U and two of V each way; the read-back pair is registered here but drives no output.
// - buffered 16 MHz line-locked clock outputs for other components.
// - all module clocks derive from incoming 16 MHz and 32 MHz line-locked clocks; the logic here runs on CLK_I and only samples their edges.
// - all module control is generated here except read control of memories b and c; the logic here drives strobes for memories a and d only.
// - settings arrive over a three-wire serial bus: data, clock, reset.
// - serial transfers are synchronous, eight bits, no parity, both directions.
// - delay is 1.5 fields rounded to whole lines, except in picture-in-picture bypass mode.
// - odd and even field line counts are measured and set the delay.
// - picture-in-picture mode cuts the delay to exactly one line.
// - processing uses the 16 MHz sample rate and 4:1:1 chroma format.
// - field parity output low during odd field, high during even field.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module video_delay_ctrl (
   // clock and reset
   input  wire logic        CLK_I,
   input  wire logic        RSTN_I,
   // line-locked clocks and buffered 16 MHz copy
   input  wire logic        CLK16_I,
   input  wire logic        CLK32_I,
   output logic             BUF_CLK_16_OUT_O,
   // video references
   input  wire logic        WE_FRONT_I,
   input  wire logic        FRONT_VERT_REF_I,
   output logic             FRONT_VERT_REF_O,
   output logic             FRONT_VERT_REF_OE_O,
   input  wire logic        BACK_VERT_REF_I,
   output logic             BACK_VERT_REF_O,
   output logic             BACK_VERT_REF_OE_O,
   output logic             HORIZ_REF_OUT_O,
   output logic             EVEN_FIELD_O,
   // companion chip modes
   output logic             FILM_OUT_O,
   output logic             INTERP_ACTIVE_OUT_O,
   // field memory control and chroma
   output logic             MEM_A_READ_EN_O,
   output logic             MEM_A_WRITE_EN_O,
   output logic             MEM_D_READ_EN_O,
   output logic             MEM_D_WRITE_EN_O,
   output logic             MEM_A_D_PTR_RESET_O,
   input  wire logic [1:0]  CHROMA_U_I,
   input  wire logic [1:0]  CHROMA_V_I,
   output logic [1:0]       MEM_D_U_OUT_O,
   output logic [1:0]       MEM_D_V_OUT_O,
   input  wire logic [1:0]  MEM_D_U_IN_I,
   input  wire logic [1:0]  MEM_D_V_IN_I,
   // three-wire control bus
   input  wire logic        CTRL_BUS_CLOCK_I,
   input  wire logic        CTRL_BUS_RESET_I,
   input  wire logic        CTRL_BUS_DATA_I,
   output logic             CTRL_BUS_DATA_O,
   output logic             CTRL_BUS_DATA_OE_O,
   // axi4-lite slave
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY
);

   // ============================================================
   // reset release
   logic [1:0]            rst_sync_ff;
   logic                  rstn;
   vdc_pkg::state_t       st_ff;
   vdc_pkg::state_t       nxt_st;

   // two stages so the release never lands close to a clock edge
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rstn = rst_sync_ff[1];

   // ============================================================
   // register read decode, shared by the bus read path
   function automatic logic [31:0] read_word(input vdc_pkg::state_t s, input logic [7:0] a);
      case (a)
         vdc_pkg::ADDR_CTRL:   read_word = {28'h0000000, s.ctrl};
         vdc_pkg::ADDR_STATUS: read_word = {16'h0000, s.rx_byte, 6'h00, s.ctrl[vdc_pkg::CTRL_PIP], s.parity};
         vdc_pkg::ADDR_ODD:    read_word = {22'h000000, s.odd_lines};
         vdc_pkg::ADDR_EVEN:   read_word = {22'h000000, s.even_lines};
         vdc_pkg::ADDR_DELAY:  read_word = {22'h000000, s.dly_lines};
         vdc_pkg::ADDR_TXBYTE: read_word = {24'h000000, s.tx_byte};
         default:              read_word = 32'h00000000;
      endcase
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == vdc_pkg::ADDR_CTRL) || (a == vdc_pkg::ADDR_STATUS) || (a == vdc_pkg::ADDR_ODD) ||
                (a == vdc_pkg::ADDR_EVEN) || (a == vdc_pkg::ADDR_DELAY) || (a == vdc_pkg::ADDR_TXBYTE);
   endfunction

   // ============================================================
   // combinational helpers
   logic pip;
   logic clk32_rise;
   logic clk16_rise;
   logic line_start;
   logic vert_in;
   logic sclk_rise;
   localparam int LINE_HALF_W = vdc_pkg::LINE_W;
   logic aw_fire;
   logic w_fire;
   logic [LINE_HALF_W-1:0] half_field;

   assign pip        = st_ff.ctrl[vdc_pkg::CTRL_PIP];
   assign clk32_rise = CLK32_I & ~st_ff.clk32_q;
   assign clk16_rise = CLK16_I & ~st_ff.clk16_q;
   assign line_start = WE_FRONT_I & ~st_ff.we_q;
   // the vertical source follows the pin direction
   assign vert_in    = pip ? (BACK_VERT_REF_I & ~st_ff.vb_q) : (FRONT_VERT_REF_I & ~st_ff.vf_q);
   assign sclk_rise  = CTRL_BUS_CLOCK_I & ~st_ff.sclk_q;
   assign aw_fire    = S_AXI_AWVALID & S_AXI_AWREADY;
   assign w_fire     = S_AXI_WVALID & S_AXI_WREADY;
   // half the field just closed, rounded up; pulse lands half a field after the next vertical,
   // i.e. 1.5 fields after the field it belongs to, which avoids two countdowns in flight
   assign half_field = LINE_HALF_W'((st_ff.line_cnt + 10'h001) >> 1);

   // ============================================================
   // next-state logic
   always_comb begin
      nxt_st = st_ff;
      nxt_st.clk16_q     = CLK16_I;
      nxt_st.clk32_q     = CLK32_I;
      nxt_st.we_q        = WE_FRONT_I;
      nxt_st.vf_q        = FRONT_VERT_REF_I;
      nxt_st.vb_q        = BACK_VERT_REF_I;
      nxt_st.sclk_q      = CTRL_BUS_CLOCK_I;
      nxt_st.href        = line_start;
      nxt_st.back_pulse  = 1'b0;
      nxt_st.front_pulse = 1'b0;
      nxt_st.ptr_rst     = 1'b0;

      // line and field measurement
      if (line_start) begin
         nxt_st.line_cnt = st_ff.line_cnt + 10'h001;
      end
      if (vert_in) begin
         if (st_ff.parity) begin
            nxt_st.even_lines = st_ff.line_cnt;
         end else begin
            nxt_st.odd_lines = st_ff.line_cnt;
         end
         nxt_st.line_cnt  = '0;
         nxt_st.parity    = ~st_ff.parity;
         nxt_st.ptr_rst   = 1'b1;
         nxt_st.dly_lines = pip ? vdc_pkg::PIP_DELAY : half_field;
         nxt_st.dly_cnt   = pip ? vdc_pkg::PIP_DELAY : half_field;
         nxt_st.dly_run   = 1'b1;
      end else if (st_ff.dly_run && line_start) begin
         // count whole lines so the delay is rounded to complete lines
         if (st_ff.dly_cnt <= 10'h001) begin
            nxt_st.dly_run = 1'b0;
            if (pip) begin
               nxt_st.front_pulse = 1'b1;
            end else begin
               nxt_st.back_pulse = 1'b1;
            end
         end else begin
            nxt_st.dly_cnt = st_ff.dly_cnt - 10'h001;
         end
      end

      // mode outputs and strobes move only on 32 MHz edges
      if (clk32_rise) begin
         nxt_st.film     = pip | st_ff.ctrl[vdc_pkg::CTRL_FILM];
         nxt_st.interp   = ~pip & st_ff.ctrl[vdc_pkg::CTRL_INTERP];
         // odd field is written, even field read back against it
         nxt_st.mem_a_we = WE_FRONT_I & ~st_ff.parity;
         nxt_st.mem_a_re = WE_FRONT_I & st_ff.parity;
         nxt_st.mem_d_we = WE_FRONT_I & ~st_ff.parity;
         nxt_st.mem_d_re = WE_FRONT_I & st_ff.parity;
      end

      // chroma moves one 2+2 bit pair per 16 MHz sample
      if (clk16_rise) begin
         nxt_st.u_out = CHROMA_U_I;
         nxt_st.v_out = CHROMA_V_I;
         nxt_st.u_rd  = MEM_D_U_IN_I;
         nxt_st.v_rd  = MEM_D_V_IN_I;
      end

      // three-wire bus: eight bits, msb first, no parity
      if (CTRL_BUS_RESET_I) begin
         nxt_st.bit_cnt = 4'h0;
         nxt_st.txing   = 1'b0;
      end else if (sclk_rise) begin
         if (st_ff.txing) begin
            nxt_st.shreg = {st_ff.shreg[6:0], 1'b0};
         end else begin
            nxt_st.shreg = {st_ff.shreg[6:0], CTRL_BUS_DATA_I};
         end
         nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
         if (st_ff.bit_cnt == vdc_pkg::BYTE_BITS - 4'h1) begin
            nxt_st.bit_cnt = 4'h0;
            if (st_ff.txing) begin
               nxt_st.txing = 1'b0;
            end else begin
               nxt_st.rx_byte = {st_ff.shreg[6:0], CTRL_BUS_DATA_I};
               if (st_ff.shreg[vdc_pkg::SBUS_READ_BIT-1]) begin
                  // read request: answer with the staged byte
                  nxt_st.txing = 1'b1;
                  nxt_st.shreg = st_ff.tx_byte;
               end else begin
                  nxt_st.ctrl = {st_ff.shreg[2:0], CTRL_BUS_DATA_I};
               end
            end
         end
      end

      // axi write channel; a bus write in the same cycle wins over a serial write
      if (aw_fire) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.awaddr = S_AXI_AWADDR;
      end
      if (w_fire) begin
         nxt_st.w_got  = 1'b1;
         nxt_st.wdata  = S_AXI_WDATA;
         nxt_st.wstrb0 = S_AXI_WSTRB[0];
      end
      if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got  = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp  = addr_ok(st_ff.awaddr) ? vdc_pkg::RESP_OKAY : vdc_pkg::RESP_DECERR;
         if (st_ff.wstrb0 && st_ff.awaddr == vdc_pkg::ADDR_CTRL) begin
            nxt_st.ctrl = st_ff.wdata[3:0];
         end
         if (st_ff.wstrb0 && st_ff.awaddr == vdc_pkg::ADDR_TXBYTE) begin
            nxt_st.tx_byte = st_ff.wdata[7:0];
         end
      end
      if (st_ff.bvalid && S_AXI_BREADY) begin
         nxt_st.bvalid = 1'b0;
      end

      // axi read channel
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata  = read_word(st_ff, S_AXI_ARADDR);
         nxt_st.rresp  = addr_ok(S_AXI_ARADDR) ? vdc_pkg::RESP_OKAY : vdc_pkg::RESP_DECERR;
      end else if (st_ff.rvalid && S_AXI_RREADY) begin
         nxt_st.rvalid = 1'b0;
      end
   end

   // ============================================================
   // state register
   always_ff @(posedge CLK_I or negedge rstn) begin
      if (!rstn) begin
         st_ff         <= '0;
         st_ff.ctrl    <= vdc_pkg::CTRL_RST;
         st_ff.tx_byte <= vdc_pkg::TXBYTE_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ============================================================
   // outputs
   assign BUF_CLK_16_OUT_O    = st_ff.clk16_q;
   assign FRONT_VERT_REF_O    = st_ff.front_pulse;
   assign FRONT_VERT_REF_OE_O = pip;
   assign BACK_VERT_REF_O     = st_ff.back_pulse;
   assign BACK_VERT_REF_OE_O  = ~pip;
   assign HORIZ_REF_OUT_O     = st_ff.href;
   assign EVEN_FIELD_O        = st_ff.parity;
   assign FILM_OUT_O          = st_ff.film;
   assign INTERP_ACTIVE_OUT_O = st_ff.interp;
   assign MEM_A_READ_EN_O     = st_ff.mem_a_re;
   assign MEM_A_WRITE_EN_O    = st_ff.mem_a_we;
   assign MEM_D_READ_EN_O     = st_ff.mem_d_re;
   assign MEM_D_WRITE_EN_O    = st_ff.mem_d_we;
   assign MEM_A_D_PTR_RESET_O = st_ff.ptr_rst;
   assign MEM_D_U_OUT_O       = st_ff.u_out;
   assign MEM_D_V_OUT_O       = st_ff.v_out;
   assign CTRL_BUS_DATA_O     = st_ff.shreg[7];
   assign CTRL_BUS_DATA_OE_O  = st_ff.txing;
   assign S_AXI_AWREADY       = ~st_ff.aw_got & ~st_ff.bvalid;
   assign S_AXI_WREADY        = ~st_ff.w_got & ~st_ff.bvalid;
   assign S_AXI_BVALID        = st_ff.bvalid;
   assign S_AXI_BRESP         = st_ff.bresp;
   assign S_AXI_ARREADY       = ~st_ff.rvalid;
   assign S_AXI_RVALID        = st_ff.rvalid;
   assign S_AXI_RDATA         = st_ff.rdata;
   assign S_AXI_RRESP         = st_ff.rresp;

   // ============================================================
   // assertions
   sequence s_vert_odd;
      vert_in && !st_ff.parity;
   endsequence

   sequence s_both_taken;
      st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
   endsequence

   a_film_camera: assert property (@(posedge CLK_I) disable iff (!rstn)
      (clk32_rise && !pip) |=> (FILM_OUT_O == $past(st_ff.ctrl[vdc_pkg::CTRL_FILM])))
      else $error("film select does not follow control");
   a_pip_bypass: assert property (@(posedge CLK_I) disable iff (!rstn)
      (clk32_rise && pip) |=> (FILM_OUT_O && !INTERP_ACTIVE_OUT_O))
      else $error("pip bypass modes wrong");
   a_interp_set: assert property (@(posedge CLK_I) disable iff (!rstn)
      !clk32_rise |=> $stable(INTERP_ACTIVE_OUT_O))
      else $error("interpolation output moved off a 32 MHz edge");
   a_pin_dir: assert property (@(posedge CLK_I) disable iff (!rstn)
      FRONT_VERT_REF_OE_O != BACK_VERT_REF_OE_O)
      else $error("both vertical pins share one direction");
   a_href_pulse: assert property (@(posedge CLK_I) disable iff (!rstn)
      line_start |=> HORIZ_REF_OUT_O ##1 !HORIZ_REF_OUT_O)
      else $error("horizontal reference not one cycle after line start");
   a_ptr_reset: assert property (@(posedge CLK_I) disable iff (!rstn)
      vert_in |=> MEM_A_D_PTR_RESET_O)
      else $error("pointer reset missing on vertical");
   a_odd_latch: assert property (@(posedge CLK_I) disable iff (!rstn)
      s_vert_odd |=> (st_ff.odd_lines == $past(st_ff.line_cnt)) && (st_ff.line_cnt == '0))
      else $error("odd field count not latched and cleared");
   a_parity_flip: assert property (@(posedge CLK_I) disable iff (!rstn)
      vert_in |=> (EVEN_FIELD_O != $past(EVEN_FIELD_O)))
      else $error("field parity did not toggle");
   a_pip_delay: assert property (@(posedge CLK_I) disable iff (!rstn)
      (vert_in && pip) |=> (st_ff.dly_lines == vdc_pkg::PIP_DELAY))
      else $error("pip delay is not one line");
   a_strobe_excl: assert property (@(posedge CLK_I) disable iff (!rstn)
      !(MEM_A_READ_EN_O && MEM_A_WRITE_EN_O))
      else $error("memory a read and write together");
   a_write_resp: assert property (@(posedge CLK_I) disable iff (!rstn)
      s_both_taken |=> S_AXI_BVALID)
      else $error("write response late");

endmodule

// file: common/vdc_pkg.sv
// package: register map, field layout and state record of the video delay controller
package vdc_pkg;

   // ============================================================
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_ODD    = 8'h08;
   localparam logic [7:0] ADDR_EVEN   = 8'h0C;
   localparam logic [7:0] ADDR_DELAY  = 8'h10;
   localparam logic [7:0] ADDR_TXBYTE = 8'h14;

   // ============================================================
   // control field positions and reset values
   localparam int CTRL_FILM   = 0;
   localparam int CTRL_INTERP = 1;
   localparam int CTRL_PIP    = 2;
   localparam int CTRL_BYPASS = 3;
   localparam logic [3:0] CTRL_RST   = 4'h0;
   localparam logic [7:0] TXBYTE_RST = 8'h00;

   // ============================================================
   // widths and serial bus constants
   localparam int LINE_W = 10;
   localparam logic [3:0] BYTE_BITS  = 4'h8;
   localparam int SBUS_READ_BIT      = 7;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   localparam logic [LINE_W-1:0] PIP_DELAY = 10'h001;

   // ============================================================
   // whole state record of the controller
   typedef struct packed {
      logic              clk16_q;
      logic              clk32_q;
      logic              film;
      logic              interp;
      logic              we_q;
      logic              vf_q;
      logic              vb_q;
      logic              parity;
      logic [LINE_W-1:0] line_cnt;
      logic [LINE_W-1:0] odd_lines;
      logic [LINE_W-1:0] even_lines;
      logic [LINE_W-1:0] dly_lines;
      logic [LINE_W-1:0] dly_cnt;
      logic              dly_run;
      logic              back_pulse;
      logic              front_pulse;
      logic              href;
      logic              mem_a_we;
      logic              mem_a_re;
      logic              mem_d_we;
      logic              mem_d_re;
      logic              ptr_rst;
      logic [1:0]        u_out;
      logic [1:0]        v_out;
      logic [1:0]        u_rd;
      logic [1:0]        v_rd;
      logic [3:0]        ctrl;
      logic [7:0]        tx_byte;
      logic [7:0]        rx_byte;
      logic [7:0]        shreg;
      logic [3:0]        bit_cnt;
      logic              txing;
      logic              sclk_q;
      logic              aw_got;
      logic [7:0]        awaddr;
      logic              w_got;
      logic [31:0]       wdata;
      logic              wstrb0;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } state_t;

endpackage

// file: tb/ctrl_host_model.sv
// partner model: host end of the three-wire control bus
`timescale 1ns/1ps
module ctrl_host_model (
   // bench clock
   input  wire logic clk_i,
   // bus lines driven by the host
   output logic      sclk_o,
   output logic      srst_o,
   output logic      sdat_o,
   // resolved data line
   input  wire logic dev_dat_i
);
   // ============================================================
   // idle levels: clock stands still outside frames
   initial begin
      sclk_o = 1'h0;
      srst_o = 1'h0;
      sdat_o = 1'h0;
   end

   // ============================================================
   // one byte each way, msb first, no parity; sampled before each rise
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sdat_o <= tx[i];
         repeat (2) @(posedge clk_i);
         @(negedge clk_i) rx[i] = dev_dat_i;
         @(posedge clk_i) sclk_o <= 1'h1;
         repeat (2) @(posedge clk_i);
         sclk_o <= 1'h0;
      end
      // released line shows the inverse so a stale bit never passes
      sdat_o <= ~tx[0];
      @(posedge clk_i);
   endtask

   // ============================================================
   // three bits of a byte, then a reset pulse that must drop them
   task automatic cut(input logic [7:0] tx);
      for (int i = 7; i >= 5; i--) begin
         sdat_o <= tx[i];
         repeat (2) @(posedge clk_i);
         sclk_o <= 1'h1;
         repeat (2) @(posedge clk_i);
         sclk_o <= 1'h0;
      end
      srst_o <= 1'h1;
      repeat (2) @(posedge clk_i);
      srst_o <= 1'h0;
      @(posedge clk_i);
   endtask
endmodule

// file: tb/test_video_delay_ctrl.sv
// testbench: mode outputs, field measurement, memory strobes and serial control
`timescale 1ns/1ps
module test_video_delay_ctrl;
   logic        CLK_I = '0, RSTN_I = '0, CLK16_I = '0, CLK32_I = '0, WE_FRONT_I = '0, fv = '0, bv = '0;
   logic [1:0]  CHROMA_U_I = '0, CHROMA_V_I = '0, MEM_D_U_IN_I = '0, MEM_D_V_IN_I = '0;
   logic        S_AXI_AWVALID = '0, S_AXI_WVALID = '0, S_AXI_BREADY = '0, S_AXI_ARVALID = '0, S_AXI_RREADY = '0;
   logic [7:0]  S_AXI_AWADDR = '0, S_AXI_ARADDR = '0, rx, tb;
   logic [31:0] S_AXI_WDATA = '0;
   logic [3:0]  S_AXI_WSTRB = 4'hF, m;
   logic [2:0]  cnt = '0;
   logic        c16d = '0;
   logic [33:0] q[$];
   int          fail_count = 0, check_count = 0, ptrs = 0, hrefs = 0, fronts = 0, backs = 0;
   wire         BUF_CLK_16_OUT_O, FRONT_VERT_REF_O, FRONT_VERT_REF_OE_O, BACK_VERT_REF_O, BACK_VERT_REF_OE_O;
   wire         HORIZ_REF_OUT_O, EVEN_FIELD_O, FILM_OUT_O, INTERP_ACTIVE_OUT_O, MEM_A_READ_EN_O, MEM_A_WRITE_EN_O;
   wire         MEM_D_READ_EN_O, MEM_D_WRITE_EN_O, MEM_A_D_PTR_RESET_O, CTRL_BUS_DATA_O, CTRL_BUS_DATA_OE_O, sdat;
   wire         S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, CTRL_BUS_CLOCK_I, CTRL_BUS_RESET_I;
   wire [1:0]   MEM_D_U_OUT_O, MEM_D_V_OUT_O, S_AXI_BRESP, S_AXI_RRESP;
   wire [31:0]  S_AXI_RDATA;
   // two-way pins resolved from the enables
   wire         FRONT_VERT_REF_I = FRONT_VERT_REF_OE_O ? FRONT_VERT_REF_O : fv;
   wire         BACK_VERT_REF_I = BACK_VERT_REF_OE_O ? BACK_VERT_REF_O : bv;
   wire         CTRL_BUS_DATA_I = CTRL_BUS_DATA_OE_O ? CTRL_BUS_DATA_O : sdat;

   video_delay_ctrl uut (.CLK_I, .RSTN_I, .CLK16_I, .CLK32_I, .BUF_CLK_16_OUT_O, .WE_FRONT_I, .FRONT_VERT_REF_I,
      .FRONT_VERT_REF_O, .FRONT_VERT_REF_OE_O, .BACK_VERT_REF_I, .BACK_VERT_REF_O, .BACK_VERT_REF_OE_O,
      .HORIZ_REF_OUT_O, .EVEN_FIELD_O, .FILM_OUT_O, .INTERP_ACTIVE_OUT_O, .MEM_A_READ_EN_O, .MEM_A_WRITE_EN_O,
      .MEM_D_READ_EN_O, .MEM_D_WRITE_EN_O, .MEM_A_D_PTR_RESET_O, .CHROMA_U_I, .CHROMA_V_I, .MEM_D_U_OUT_O,
      .MEM_D_V_OUT_O, .MEM_D_U_IN_I, .MEM_D_V_IN_I, .CTRL_BUS_CLOCK_I, .CTRL_BUS_RESET_I, .CTRL_BUS_DATA_I,
      .CTRL_BUS_DATA_O, .CTRL_BUS_DATA_OE_O, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
      .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
      .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
   ctrl_host_model host (.clk_i(CLK_I), .sclk_o(CTRL_BUS_CLOCK_I), .srst_o(CTRL_BUS_RESET_I), .sdat_o(sdat),
      .dev_dat_i(CTRL_BUS_DATA_I));

   // ============================================================
   // clocks: line-locked copies kept below half the bench rate so each edge is seen
   always #12.5 CLK_I = ~CLK_I;
   always @(posedge CLK_I) begin
      cnt <= cnt + 3'h1;
      {CLK16_I, CLK32_I} <= {cnt[2], cnt[1]};
      c16d <= CLK16_I;
   end

   // ============================================================
   // compare, response monitor and pulse counters
   task automatic cmp(input string nm, input logic [33:0] e, input logic [33:0] s);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask
   always @(posedge CLK_I) begin
      if (S_AXI_BVALID && S_AXI_BREADY) cmp("bresp", q.pop_front(), {S_AXI_BRESP, 32'h0});
      if (S_AXI_RVALID && S_AXI_RREADY) cmp("rdata", q.pop_front(), {S_AXI_RRESP, S_AXI_RDATA});
      ptrs += (MEM_A_D_PTR_RESET_O === 1'h1);
      hrefs += (HORIZ_REF_OUT_O === 1'h1);
      fronts += (FRONT_VERT_REF_O === 1'h1);
      backs += (BACK_VERT_REF_O === 1'h1);
   end

   // ============================================================
   // bus and video drivers
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      q.push_back({r, 32'h0});
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'h1;
      S_AXI_WVALID <= 1'h1;
      S_AXI_BREADY <= 1'h1;
      do begin
         @(posedge CLK_I);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
      end while (S_AXI_BVALID !== 1'h1);
      S_AXI_BREADY <= 1'h0;
      @(posedge CLK_I);
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      q.push_back(e);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'h1;
      S_AXI_RREADY <= 1'h1;
      do begin
         @(posedge CLK_I);
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
      end while (S_AXI_RVALID !== 1'h1);
      S_AXI_RREADY <= 1'h0;
      @(posedge CLK_I);
   endtask
   task automatic vert(input logic back, input logic ev);
      if (back) bv <= 1'h1;
      else fv <= 1'h1;
      @(posedge CLK_I);
      bv <= 1'h0;
      fv <= 1'h0;
      repeat (3) @(posedge CLK_I);
      cmp("even", {33'h0, ev}, {33'h0, EVEN_FIELD_O});
   endtask
   task automatic lines(input int n, input logic ev);
      repeat (n) begin
         WE_FRONT_I <= 1'h1;
         CHROMA_U_I <= 2'($urandom());
         CHROMA_V_I <= 2'($urandom());
         MEM_D_U_IN_I <= 2'($urandom());
         repeat (10) @(posedge CLK_I);
         cmp("strobes", {30'h0, ev, ~ev, ev, ~ev},
             {30'h0, MEM_A_READ_EN_O, MEM_A_WRITE_EN_O, MEM_D_READ_EN_O, MEM_D_WRITE_EN_O});
         cmp("chroma", {30'h0, CHROMA_U_I, CHROMA_V_I}, {30'h0, MEM_D_U_OUT_O, MEM_D_V_OUT_O});
         cmp("bufclk", {33'h0, c16d}, {33'h0, BUF_CLK_16_OUT_O});
         WE_FRONT_I <= 1'h0;
         repeat (6) @(posedge CLK_I);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // ============================================================
   // main sequence and watchdog
   initial begin
      repeat (20000) @(posedge CLK_I);
      fail_count++;
      summarize();
   end
   initial begin
      void'($urandom(17));
      repeat (12) @(posedge CLK_I);
      RSTN_I <= 1'h1;
      repeat (4) @(posedge CLK_I);
      cmp("vref_oe", 34'h1, {32'h0, FRONT_VERT_REF_OE_O, BACK_VERT_REF_OE_O});
      for (int i = 0; i < 16; i++) begin
         m = 4'(i);
         wr(vdc_pkg::ADDR_CTRL, {24'($urandom()), 4'h0, m}, vdc_pkg::RESP_OKAY);
         repeat (6) @(posedge CLK_I);
         cmp("modes", {32'h0, m[2] | m[0], ~m[2] & m[1]}, {32'h0, FILM_OUT_O, INTERP_ACTIVE_OUT_O});
         rd(vdc_pkg::ADDR_CTRL, {2'h0, 28'h0, m});
      end
      cmp("vref_oe", 34'h2, {32'h0, FRONT_VERT_REF_OE_O, BACK_VERT_REF_OE_O});
      vert(1'h1, 1'h1);
      lines(3, 1'h1);
      vert(1'h1, 1'h0);
      rd(vdc_pkg::ADDR_DELAY, {2'h0, 32'h1});
      wr(vdc_pkg::ADDR_CTRL, 32'h0, vdc_pkg::RESP_OKAY);
      vert(1'h0, 1'h1);
      lines(5, 1'h1);
      vert(1'h0, 1'h0);
      lines(7, 1'h0);
      vert(1'h0, 1'h1);
      rd(vdc_pkg::ADDR_ODD, {2'h0, 32'h7});
      rd(vdc_pkg::ADDR_EVEN, {2'h0, 32'h5});
      rd(vdc_pkg::ADDR_DELAY, {2'h0, 32'h4});
      cmp("ptr_reset", 34'h5, 34'(ptrs));
      cmp("href", 34'hF, 34'(hrefs));
      cmp("front", 34'h1, 34'(fronts));
      cmp("back", 34'h2, 34'(backs));
      wr(8'h18, $urandom(), vdc_pkg::RESP_DECERR);
      rd(8'h18, {vdc_pkg::RESP_DECERR, 32'h0});
      // a write without the low byte lane must leave the control bits alone
      S_AXI_WSTRB <= 4'hE;
      wr(vdc_pkg::ADDR_CTRL, 32'hF, vdc_pkg::RESP_OKAY);
      S_AXI_WSTRB <= 4'hF;
      rd(vdc_pkg::ADDR_CTRL, {2'h0, 32'h0});
      host.cut(8'hFF);
      host.xfer(8'h09, rx);
      rd(vdc_pkg::ADDR_CTRL, {2'h0, 32'h9});
      tb = 8'($urandom());
      wr(vdc_pkg::ADDR_TXBYTE, {24'h0, tb}, vdc_pkg::RESP_OKAY);
      host.xfer(8'h80, rx);
      host.xfer(8'h00, rx);
      cmp("serial", {26'h0, tb}, {26'h0, rx});
      rd(vdc_pkg::ADDR_STATUS, {2'h0, 32'h8001});
      summarize();
   end
endmodule
